/* hw/afx_pkg.sv */
// Package with register map, field layout and timing constants for the filter and excitation control.
package afx_pkg;

  localparam logic [7:0] AFX_ADDR_DECIM = 8'hd4;
  localparam logic [7:0] AFX_ADDR_EXC = 8'hd5;
  localparam logic [7:0] AFX_DECIM_RESET = 8'h45;
  localparam logic [7:0] AFX_EXC_RESET = 8'h00;
  localparam logic [7:0] AFX_EXC_IMPL_MASK = 8'h4f;
  localparam logic [7:0] AFX_DECIM_CHOP_MIN = 8'h0d;
  localparam logic [7:0] AFX_DECIM_CAL_BEST = 8'hff;

  localparam int AFX_BIT_FIRST_EN = 0;
  localparam int AFX_BIT_SECOND_EN = 1;
  localparam int AFX_BIT_FIRST_SEL = 2;
  localparam int AFX_BIT_SECOND_SEL = 3;
  localparam int AFX_BIT_BURNOUT = 6;

  // Base modulator rate and the decimation multipliers.
  localparam int AFX_BASE_HZ = 32768;
  localparam int AFX_CLK_HZ = 100000000;
  localparam int AFX_MUL_CHOP_OFF = 8;
  localparam int AFX_MUL_CHOP_ON = 24;
  // Core clocks per base-rate tick, rounded down.
  localparam int AFX_TICK_CYCLES = AFX_CLK_HZ / AFX_BASE_HZ;
  localparam logic [11:0] AFX_TICK_LAST = 12'(AFX_TICK_CYCLES - 1);

  // Pin routing of the two excitation sources.
  typedef struct packed {
    logic first_to_seven;
    logic first_to_eight;
    logic second_to_seven;
    logic second_to_eight;
  } afx_exc_route_t;

  typedef struct packed {
    logic burnout_pair_56;
    logic burnout_pair_78;
  } afx_burnout_t;

endpackage

/* hw/afx_ctrl.sv */
// Decimation word and excitation current source control with conversion pacing.
`timescale 1ns/1ps

// Operation
// - Chop on: rate is base/(24*word).
// - Chop off: rate is base/(8*word).
// - Whole 8-bit register is the decimation word.
// - Chop on clamps words below 13 up.
// - Calibration uses the programmed word.
// - Decimation register at d4, reset 45.
// - Current control register at d5, reset 00.
// - Burnout only on input pairs 5/6, 7/8.
// - Bit 3 routes second source 8/7.
// - Bit 2 routes first source 7/8.
// - Bits 1,0 enable second, first source.
// - Current writes never restart a conversion.
// - Both sources may share one pin.
// - Unimplemented bits ignore writes.
module afx_ctrl
(
  // Clock and reset
  input wire logic core_clk_i,
  input wire logic rst_i,
  // Special function register bus
  input wire logic [7:0] sfr_addr_i,
  input wire logic sfr_wr_i,
  input wire logic [7:0] sfr_wdata_i,
  output logic [7:0] sfr_rdata_o,
  // Converter mode and pair selection
  input wire logic chop_disable_i,
  input wire logic calibrating_i,
  input wire logic pair_56_sel_i,
  input wire logic pair_78_sel_i,
  // Converter controls
  output logic [7:0] decimation_value_o,
  output logic conv_done_o,
  output afx_pkg::afx_exc_route_t exc_route_o,
  output afx_pkg::afx_burnout_t burnout_o
);
  import afx_pkg::*;

  logic [7:0] decim_reg;
  logic [7:0] exc_reg;
  logic [7:0] eff_word;
  logic [11:0] tick_cnt_reg;
  logic [12:0] dec_cnt_reg;
  logic [12:0] dec_last;
  logic tick;

  // Clamped word the filter actually uses.
  function automatic logic [7:0] afx_eff_word(input logic [7:0] w, input logic chop_off);
    logic [7:0] r;
    r = w;
    if (!chop_off && (w < AFX_DECIM_CHOP_MIN))
    begin
      r = AFX_DECIM_CHOP_MIN;
    end
    return r;
  endfunction

  // Write strobe aimed at one register address.
  function automatic logic afx_wr_hit(input logic wr, input logic [7:0] addr, input logic [7:0] target);
    return wr && (addr == target);
  endfunction

  // Pin decode of one source, as {to_seven, to_eight}; a disabled source drives neither pin.
  function automatic logic [1:0] afx_pin_route(input logic en, input logic to_seven);
    logic [1:0] p;
    p = 2'b00;
    if (en)
    begin
      p = {to_seven, ~to_seven};
    end
    return p;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // decimation register write
  always_ff @(posedge core_clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      decim_reg <= AFX_DECIM_RESET;
    end
    else if (afx_wr_hit(sfr_wr_i, sfr_addr_i, AFX_ADDR_DECIM))
    begin
      decim_reg <= sfr_wdata_i;
    end
  end

  always_ff @(posedge core_clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      exc_reg <= AFX_EXC_RESET;
    end
    else if (afx_wr_hit(sfr_wr_i, sfr_addr_i, AFX_ADDR_EXC))
    begin
      exc_reg <= sfr_wdata_i & AFX_EXC_IMPL_MASK;
    end
  end

  // Unmapped addresses read as zero.
  // Read data is registered, so it trails the address by one cycle.
  always_ff @(posedge core_clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      sfr_rdata_o <= 8'h00;
    end
    else if (sfr_addr_i == AFX_ADDR_DECIM)
    begin
      sfr_rdata_o <= decim_reg;
    end
    else if (sfr_addr_i == AFX_ADDR_EXC)
    begin
      sfr_rdata_o <= exc_reg;
    end
    else
    begin
      sfr_rdata_o <= 8'h00;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // The sample pacing is kept in 32.768 kHz ticks; the divider truncates, so
  // the tick runs very slightly fast, which is below the filter's resolution.
  // A decimation change applies to the running count, so one period may be short.
  // The calibration flag is deliberately not read: calibration runs at the programmed
  // word, so software that wants the cleanest calibration writes the largest word first.
  // calibration keeps programmed word
  assign eff_word = afx_eff_word(decim_reg, chop_disable_i);
  assign dec_last = chop_disable_i ?
    13'(AFX_MUL_CHOP_OFF * int'(eff_word) - 1) : 13'(AFX_MUL_CHOP_ON * int'(eff_word) - 1);
  assign tick = (tick_cnt_reg == AFX_TICK_LAST);

  always_ff @(posedge core_clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      tick_cnt_reg <= 12'h000;
    end
    else if (tick)
    begin
      tick_cnt_reg <= 12'h000;
    end
    else
    begin
      tick_cnt_reg <= tick_cnt_reg + 12'h001;
    end
  end

  always_ff @(posedge core_clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      dec_cnt_reg <= 13'h0000;
      conv_done_o <= 1'b0;
    end
    else
    begin
      conv_done_o <= 1'b0;
      if (tick)
      begin
        if (dec_cnt_reg >= dec_last)
        begin
          dec_cnt_reg <= 13'h0000;
          conv_done_o <= 1'b1;
        end
        else
        begin
          dec_cnt_reg <= dec_cnt_reg + 13'h0001;
        end
      end
    end
  end

  always_ff @(posedge core_clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      decimation_value_o <= AFX_DECIM_RESET;
    end
    else
    begin
      decimation_value_o <= eff_word;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Routing is decoded per source, so two sources on one pin is legal.
  always_ff @(posedge core_clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      exc_route_o <= '0;
      burnout_o <= '0;
    end
    else
    begin
      {exc_route_o.first_to_seven, exc_route_o.first_to_eight} <=
        afx_pin_route(exc_reg[AFX_BIT_FIRST_EN], ~exc_reg[AFX_BIT_FIRST_SEL]);
      {exc_route_o.second_to_seven, exc_route_o.second_to_eight} <=
        afx_pin_route(exc_reg[AFX_BIT_SECOND_EN], exc_reg[AFX_BIT_SECOND_SEL]);
      burnout_o.burnout_pair_56 <= exc_reg[AFX_BIT_BURNOUT] & pair_56_sel_i;
      burnout_o.burnout_pair_78 <= exc_reg[AFX_BIT_BURNOUT] & pair_78_sel_i;
    end
  end

endmodule

/* tb/afx_ctrl_monitor.sv */
// Port checker for the filter and excitation control.
`timescale 1ns/1ps
module afx_ctrl_monitor
(
  // Clock, reset and register bus
  input wire logic core_clk_i,
  input wire logic rst_i,
  input wire logic [7:0] sfr_addr_i,
  input wire logic sfr_wr_i,
  input wire logic [7:0] sfr_wdata_i,
  input wire logic [7:0] sfr_rdata_o,
  // Mode inputs and converter controls
  input wire logic chop_disable_i,
  input wire logic pair_56_sel_i,
  input wire logic pair_78_sel_i,
  input wire logic [7:0] decimation_value_o,
  input wire logic conv_done_o,
  input wire afx_pkg::afx_exc_route_t exc_route_o,
  input wire afx_pkg::afx_burnout_t burnout_o
);
  import afx_pkg::*;
  logic [7:0] dec_m;
  logic [7:0] exc_m;
  logic [11:0] ph_m;
  default clocking @(posedge core_clk_i); endclocking
  default disable iff (rst_i);
  // Shadow copies, so reads and outputs are judged against what was written.
  always_ff @(posedge core_clk_i or posedge rst_i)
  begin
    if (rst_i)
      {dec_m, exc_m} <= 16'h4500;
    else if (sfr_wr_i && sfr_addr_i == 8'hd4)
      dec_m <= sfr_wdata_i;
    else if (sfr_wr_i && sfr_addr_i == 8'hd5)
      exc_m <= sfr_wdata_i & 8'h4f;
  end
  // Base-rate phase since reset; results may only land one cycle after a tick.
  always_ff @(posedge core_clk_i or posedge rst_i)
  begin
    if (rst_i)
      ph_m <= 12'h000;
    else
      ph_m <= (ph_m == AFX_TICK_LAST) ? 12'h000 : ph_m + 12'h001;
  end
  function automatic afx_exc_route_t rt(input logic [7:0] c);
    return {c[0] & !c[2], c[0] & c[2], c[1] & c[3], c[1] & !c[3]};
  endfunction
  sequence s_exc_wr;
    sfr_wr_i && sfr_addr_i == 8'hd5;
  endsequence
  a_route_map: assert property (exc_route_o == rt($past(exc_m)))
    else $error("route mismatch");
  a_write_lat: assert property (s_exc_wr |-> ##2 exc_route_o == rt($past(sfr_wdata_i, 2)))
    else $error("route latency");
  a_burn_gate: assert property (burnout_o == {$past(exc_m[6]) & $past(pair_56_sel_i),
    $past(exc_m[6]) & $past(pair_78_sel_i)}) else $error("burnout mismatch");
  a_word_clamp: assert property (decimation_value_o == (!$past(chop_disable_i) &&
    $past(dec_m) < 8'h0d ? 8'h0d : $past(dec_m))) else $error("word mismatch");
  a_read_word: assert property (sfr_addr_i == 8'hd4 |=> sfr_rdata_o == $past(dec_m))
    else $error("word read");
  a_read_ctrl: assert property (sfr_addr_i == 8'hd5 |=> sfr_rdata_o == $past(exc_m))
    else $error("control read");
  a_read_unmapped: assert property (!(sfr_addr_i inside {8'hd4, 8'hd5}) |=> sfr_rdata_o == 8'h00)
    else $error("unmapped read");
  a_done_pulse: assert property (conv_done_o |=> !conv_done_o)
    else $error("done too long");
  a_done_grid: assert property (conv_done_o |-> ph_m == 12'h000)
    else $error("done off tick grid");
endmodule

/* tb/tb_afx_ctrl.sv */
// Directed bench for the filter and excitation control.
`timescale 1ns/1ps
module tb_afx_ctrl;
  import afx_pkg::*;
  logic clk, rst, wr, chop, cal, p56, p78, done;
  logic [7:0] adr, wd, rdat, dec;
  afx_exc_route_t rt;
  afx_burnout_t bo;
  int bad_count, comparisons, cnt, gap;
  afx_ctrl i_afx_ctrl (.core_clk_i(clk), .rst_i(rst), .sfr_addr_i(adr), .sfr_wr_i(wr), .sfr_wdata_i(wd),
    .sfr_rdata_o(rdat), .chop_disable_i(chop), .calibrating_i(cal), .pair_56_sel_i(p56), .pair_78_sel_i(p78),
    .decimation_value_o(dec), .conv_done_o(done), .exc_route_o(rt), .burnout_o(bo));
  task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
    comparisons++;
    if (s !== e)
    begin
      bad_count++;
      $display("ERROR %s exp %h got %h", n, e, s);
    end
  endtask
  task automatic w(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    {adr, wd, wr} <= {a, d, 1'b1};
    @(posedge clk);
    wr <= 1'b0;
  endtask
  task automatic r(input logic [7:0] a, input logic [7:0] e);
    @(posedge clk);
    adr <= a;
    repeat (2) @(posedge clk);
    #1 chk("rdata", rdat, e);
  endtask
  task automatic conclude();
    $display("checks %0d errors %0d", comparisons, bad_count);
    if (bad_count == 0 && comparisons > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  // Cycles between result pulses; a restart on control writes would lengthen it.
  always @(posedge clk)
  begin
    cnt <= done ? 1 : cnt + 1;
    if (done)
      gap <= cnt;
  end
  initial
  begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  initial
  begin
    repeat (90000) @(posedge clk);
    bad_count++;
    conclude();
  end
  initial
  begin
    {rst, chop, p56, wr, cal, p78, adr, wd} = 22'h380000;
    {cnt, gap} = '0;
    repeat (5) @(posedge clk);
    rst <= 1'b0;
    r(8'hd4, 8'h45);
    r(8'hd5, 8'h00);
    w(8'hd4, 8'h01);
    r(8'hd4, 8'h01);
    chk("word", dec, 8'h01);
    @(posedge done);
    w(8'hd5, 8'hff);
    @(posedge done); // only the spacing is used, no result is trusted
    @(posedge clk);
    #1 chk("gap", gap, 16'(8 * AFX_TICK_CYCLES));
    r(8'hd5, 8'h4f);
    w(8'hd6, 8'hff);
    r(8'hd6, 8'h00);
    r(8'hd4, 8'h01);
    for (int c = 0; c < 16; c++)
    begin
      @(posedge clk);
      {p56, p78} <= {c[2], c[1]};
      w(8'hd5, {1'b0, c[0], 2'b00, c[3:0]});
      @(posedge clk);
      #1 chk("route", rt, {c[0] & !c[2], c[0] & c[2], c[1] & c[3], c[1] & !c[3]});
      chk("burn", bo, {c[0] & c[2], c[0] & c[1]});
    end
    @(posedge clk);
    {chop, cal} <= 2'b01;
    w(8'hd4, 8'h0c);
    @(posedge clk);
    #1 chk("word", dec, 8'h0d);
    w(8'hd4, 8'h0e);
    @(posedge clk);
    #1 chk("word", dec, 8'h0e);
    // Chop on at word 14 must stay quiet far longer than the chop-off word-1 period just left.
    repeat (30000) @(posedge clk);
    #1 chk("chop period", 32'(cnt > 8 * AFX_TICK_CYCLES), 32'h1);
    conclude();
  end
endmodule
bind afx_ctrl afx_ctrl_monitor i_afx_ctrl_monitor (.*);
